/* File: mm_map.svh */
// register map, field positions, reset values and timing constants
`ifndef MM_MAP_SVH
`define MM_MAP_SVH
// register indices, group mask and reset values; byte address is four times the index
`define IDX_OWN_ADDR  8'h48
`define IDX_CTRL_ONE  8'h49
`define IDX_CTRL_TWO  8'h4A
`define IDX_STATUS    8'h4B
`define IDX_TX_DATA   8'h4C
`define IDX_RX_DATA   8'h4D
`define IDX_CRC       8'h4E
`define IDX_DIVIDER   8'h4F
`define IDX_GROUP     8'hF8
`define RST_OWN_ADDR  8'hA0
`define RST_DIVIDER   3'h4
// own address fields
`define F_SADDR       7:1
`define B_EXT         0
// control one
`define B_EN          7
`define B_IEN         6
`define B_CLRBB       5
`define B_ACKSUP      3
`define B_RSEN        2
`define B_PECNX       1
// control two
`define B_ALF         7
`define B_NAKF        6
`define B_BB          5
`define B_MST         4
`define B_DIR         3
`define B_CRCEF       0
// status, then the divider field
`define B_RXF         7
`define B_TXF         6
`define B_MATCH       5
`define B_SRW         4
`define B_RXAK        3
`define B_CRCBF       2
`define B_TXBE        1
`define B_RXBF        0
`define F_BR          2:0
// bus side constants
`define GEN_CALL      7'h00
`define EXT_ADDR      7'h0C
`define CRC_POLY      8'h07
`define DIV_BASE      12'h010
`define CNT_LAST      4'h7
`define CNT_ACK       4'h8
`define CNT_PRE       4'hF
`define PH_LOW        2'h0
`define PH_REL        2'h1
`define PH_EDGE       2'h2
`define RESP_OK       2'h0
`define RESP_ERR      2'h2
`endif

/* File: mm_pkg.sv */
// types of the two-wire serial unit
`default_nettype none
package mm_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_LOW   = 6'h04,
    ST_HIGH  = 6'h08,
    ST_STOP  = 6'h10,
    ST_RSTRT = 6'h20
  } mst_state_e;

  typedef struct packed {
    mst_state_e  st;
    logic [11:0] tmr;
    logic [1:0]  sub;
    logic        hs;
    logic        scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, scl_lo, sda_lo;
    logic        act, tx, adr, ackd, pend;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  own_address;
    logic        module_enable_bit, interrupt_enable_bit, ack_suppress;
    logic        repeat_start_enable, pec_next_byte;
    logic        arb_lost_flag, no_ack_flag, bus_busy_flag, master_select;
    logic        master_direction, crc_err;
    logic        rx_done_flag, tx_done_flag, addr_match, slave_rw, rx_nak;
    logic        crc_full, tx_empty, rx_full;
    logic [7:0]  tx_byte, rx_byte, crc_result_reg;
    logic [2:0]  br;
    logic        awv, wv, wst, bv, rv, berr, rerr;
    logic [11:0] awa;
    logic [7:0]  wd, rd;
  } mm_state_s;
endpackage : mm_pkg
`default_nettype wire

/* File: mm_props.sv */
// checker of the serial unit's bus-side ports
`timescale 1ns/1ps
`default_nettype none
module mm_props (
  input wire logic        clk_in,      // clock
  input wire logic        rst_n_in,    // reset
  input wire logic [1:0]  bresp_out,   // b resp
  input wire logic        bvalid_out,  // b valid
  input wire logic        bready_in,   // b ready
  input wire logic [11:0] araddr_in,   // ar addr
  input wire logic        arvalid_in,  // ar valid
  input wire logic        arready_out, // ar ready
  input wire logic [31:0] rdata_out,   // r data
  input wire logic [1:0]  rresp_out,   // r resp
  input wire logic        rvalid_out,  // r valid
  input wire logic        rready_in,   // r ready
  input wire logic        scl_in,      // clock line
  input wire logic        scl_out,     // clock drive
  input wire logic        scl_oe_out,  // clock pull
  input wire logic        sda_out,     // data drive
  input wire logic        sda_oe_out,  // data pull
  input wire logic        irq_out      // irq
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rst_idle; $rose(rst_n_in) |-> !scl_oe_out && !sda_oe_out && !irq_out; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines held after reset");
  property p_od; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  // a released clock still low means another party stretches: wait
  property p_scl_wait; !scl_oe_out && !scl_in |=> !scl_oe_out; endproperty
  a_scl_wait: assert property (p_scl_wait) else $error("clock pulled while stretched");
  property p_b_hold; bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_ref; rvalid_out |-> !arready_out; endproperty
  a_ar_ref: assert property (p_ar_ref) else $error("read taken while busy");
  property p_r_err; arvalid_in && arready_out && araddr_in[11:5] != 7'h09 |=> rresp_out == 2'h2;
  endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
  property p_r_ok; arvalid_in && arready_out && araddr_in[11:5] == 7'h09 |=> rresp_out == 2'h0;
  endproperty
  a_r_ok: assert property (p_r_ok) else $error("mapped read refused");
  property p_r_upper; rvalid_out |-> rdata_out[31:8] == 24'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
endmodule : mm_props
bind multi_master_serial_unit mm_props u_props (.clk_in, .rst_n_in, .bresp_out, .bvalid_out,
  .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out,
  .rready_in, .scl_in, .scl_out, .scl_oe_out, .sda_out, .sda_oe_out, .irq_out);
`default_nettype wire

/* File: mm_slave_model.sv */
// far-side slave device: acks its address and data, stretches after each byte
`timescale 1ns/1ps
`default_nettype none
module mm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A    // answered address
) (
  input  wire logic       clk_in,       // sampling clock
  input  wire logic       scl_in,       // clock line
  input  wire logic       sda_in,       // data line
  input  wire logic [7:0] stretch_in,   // stretch cycles
  output logic            scl_oe_out,   // pull clock low
  output logic            sda_oe_out,   // pull data low
  output logic [7:0]      byte_out,     // last data byte
  output logic [3:0]      count_out,    // data bytes taken
  output logic            act_out       // inside a frame
);
  logic       scl_q, sda_q, first_q, match_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, hold_q;
  initial begin
    {scl_q, sda_q, first_q, match_q, scl_oe_out, sda_oe_out, act_out} = 7'h0;
    {bit_q, count_out, sh_q, hold_q, byte_out} = 32'h0;
  end
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    scl_oe_out <= hold_q != 8'h00;
    if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
    if (scl_in && sda_q && !sda_in) begin
      act_out <= 1'b1;
      bit_q <= 4'h0;
      first_q <= 1'b1;
    end else if (scl_in && !sda_q && sda_in) act_out <= 1'b0;
    else if (act_out && scl_in && !scl_q && bit_q < 4'h8) begin
      sh_q <= {sh_q[6:0], sda_in};
      bit_q <= bit_q + 4'h1;
    end else if (act_out && !scl_in && scl_q && bit_q == 4'h8) begin
      sda_oe_out <= first_q ? sh_q[7:1] == ADDR : match_q;
      if (first_q) match_q <= sh_q[7:1] == ADDR;
      else begin
        byte_out <= sh_q;
        count_out <= count_out + 4'h1;
      end
      bit_q <= 4'h9;
    end else if (act_out && !scl_in && scl_q && bit_q == 4'h9) begin
      sda_oe_out <= 1'b0;
      bit_q <= 4'h0;
      first_q <= 1'b0;
      hold_q <= match_q ? stretch_in : 8'h00;
    end
  end
endmodule : mm_slave_model
`default_nettype wire

/* File: multi_master_serial_unit.sv */
// multi-master two-wire serial unit with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mm_map.svh"

module multi_master_serial_unit
  import mm_pkg::*;
(
  input  wire logic        clk_in,      // system clock
  input  wire logic        rst_n_in,    // synchronous reset, active low
  input  wire logic [11:0] awaddr_in,   // write address
  input  wire logic        awvalid_in,  // write address valid
  output logic             awready_out, // write address ready
  input  wire logic [31:0] wdata_in,    // write data
  input  wire logic [3:0]  wstrb_in,    // write strobes
  input  wire logic        wvalid_in,   // write data valid
  output logic             wready_out,  // write data ready
  output logic [1:0]       bresp_out,   // write response
  output logic             bvalid_out,  // write response valid
  input  wire logic        bready_in,   // write response ready
  input  wire logic [11:0] araddr_in,   // read address
  input  wire logic        arvalid_in,  // read address valid
  output logic             arready_out, // read address ready
  output logic [31:0]      rdata_out,   // read data
  output logic [1:0]       rresp_out,   // read response
  output logic             rvalid_out,  // read data valid
  input  wire logic        rready_in,   // read data ready
  input  wire logic        scl_in,      // clock line level
  output logic             scl_out,     // clock line drive value
  output logic             scl_oe_out,  // clock line pulled low
  input  wire logic        sda_in,      // data line level
  output logic             sda_out,     // data line drive value
  output logic             sda_oe_out,  // data line pulled low
  output logic             irq_out      // interrupt request, active high
);
  import mm_pkg::*;

  mm_state_s q;
  mm_state_s n;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8

  function automatic logic [11:0] half(input logic [2:0] b);
    return `DIV_BASE << b;
  endfunction : half

  function automatic mm_state_s rst_state();
    mm_state_s s;
    s = '0;
    s.st = ST_IDLE;
    s.own_address = `RST_OWN_ADDR;
    s.rx_nak = 1'b1;
    s.tx_empty = 1'b1;
    s.br = `RST_DIVIDER;
    return s;
  endfunction : rst_state

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       sr, sf, sdet, pdet, mstst, rel, hit;
    logic [7:0] idx, c, r;
    n = q;
    // two-stage synchronisers, third stage only for edge finding
    n.scl_m = scl_in;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = sda_in;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    sr = q.scl_s & ~q.scl_p;
    sf = ~q.scl_s & q.scl_p;
    sdet = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    pdet = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    mstst = (q.st != ST_IDLE);
    c = crc8(q.crc_result_reg, q.sh);
    r = 8'h00;
    idx = 8'h00;
    hit = 1'b0;

    // register writes
    if (q.bv && bready_in) n.bv = 1'b0;
    if (awvalid_in && !q.awv && !q.bv) begin
      n.awv = 1'b1;
      n.awa = awaddr_in;
    end
    if (wvalid_in && !q.wv && !q.bv) begin
      n.wv = 1'b1;
      n.wd = wdata_in[7:0];
      n.wst = wstrb_in[0];
    end
    if (q.awv && q.wv) begin
      idx = q.awa[9:2];
      hit = (q.awa[11:10] == 2'h0) && ((idx & `IDX_GROUP) == `IDX_OWN_ADDR);
      n.awv = 1'b0;
      n.wv = 1'b0;
      n.bv = 1'b1;
      n.berr = ~hit;
      if (hit && q.wst) begin
        case (idx)
          `IDX_OWN_ADDR: n.own_address = q.wd;
          `IDX_CTRL_ONE: begin
            n.module_enable_bit = q.wd[`B_EN];
            n.interrupt_enable_bit = q.wd[`B_IEN];
            if (q.wd[`B_CLRBB]) n.bus_busy_flag = 1'b0;
            n.ack_suppress = q.wd[`B_ACKSUP];
            n.repeat_start_enable = q.wd[`B_RSEN];
            n.pec_next_byte = q.wd[`B_PECNX];
          end
          `IDX_CTRL_TWO: begin
            if (!q.wd[`B_ALF]) n.arb_lost_flag = 1'b0;
            if (!q.wd[`B_NAKF]) n.no_ack_flag = 1'b0;
            n.master_select = q.wd[`B_MST];
            n.master_direction = q.wd[`B_DIR];
          end
          `IDX_STATUS: begin
            if (!q.wd[`B_RXF]) n.rx_done_flag = 1'b0;
            if (!q.wd[`B_TXF]) n.tx_done_flag = 1'b0;
          end
          `IDX_TX_DATA: begin
            n.tx_byte = q.wd;
            n.tx_empty = 1'b0;
          end
          `IDX_DIVIDER: n.br = q.wd[`F_BR];
          default: ;
        endcase
      end
    end

    // register reads
    if (q.rv && rready_in) n.rv = 1'b0;
    if (arvalid_in && !q.rv) begin
      idx = araddr_in[9:2];
      hit = (araddr_in[11:10] == 2'h0) && ((idx & `IDX_GROUP) == `IDX_OWN_ADDR);
      case (idx)
        `IDX_OWN_ADDR: r = q.own_address;
        `IDX_CTRL_ONE: begin
          r[`B_EN] = q.module_enable_bit;
          r[`B_IEN] = q.interrupt_enable_bit;
          r[`B_ACKSUP] = q.ack_suppress;
          r[`B_RSEN] = q.repeat_start_enable;
          r[`B_PECNX] = q.pec_next_byte;
        end
        `IDX_CTRL_TWO: begin
          r[`B_ALF] = q.arb_lost_flag;
          r[`B_NAKF] = q.no_ack_flag;
          r[`B_BB] = q.bus_busy_flag;
          r[`B_MST] = q.master_select;
          r[`B_DIR] = q.master_direction;
          r[`B_CRCEF] = q.crc_err;
        end
        `IDX_STATUS: begin
          r[`B_RXF] = q.rx_done_flag;
          r[`B_TXF] = q.tx_done_flag;
          r[`B_MATCH] = q.addr_match;
          r[`B_SRW] = q.slave_rw;
          r[`B_RXAK] = q.rx_nak;
          r[`B_CRCBF] = q.crc_full;
          r[`B_TXBE] = q.tx_empty;
          r[`B_RXBF] = q.rx_full;
        end
        `IDX_TX_DATA: r = q.tx_byte;
        `IDX_RX_DATA: begin
          r = q.rx_byte;
          if (hit) n.rx_full = 1'b0;
        end
        `IDX_CRC: begin
          r = q.crc_result_reg;
          if (hit) n.crc_full = 1'b0;
        end
        `IDX_DIVIDER: r[`F_BR] = q.br;
        default: r = 8'h00;
      endcase
      n.rv = 1'b1;
      n.rerr = ~hit;
      n.rd = hit ? r : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // master clock and framing; released phases count only while line high
    rel = (q.st == ST_HIGH) || ((q.st == ST_STOP || q.st == ST_RSTRT) && q.sub != `PH_LOW);
    if (q.tmr != 12'h000 && (!rel || q.scl_s)) n.tmr = q.tmr - 12'h001;
    case (q.st)
      ST_IDLE: begin
        if (q.master_select && q.module_enable_bit) begin
          if (q.bus_busy_flag) begin
            n.arb_lost_flag = 1'b1;
            n.master_select = 1'b0;
          end else begin
            n.st = ST_START;
            n.tmr = half(q.br);
          end
        end
      end
      ST_START: begin
        if (q.tmr == 12'h000) begin
          n.st = ST_LOW;
          n.tmr = half(q.br);
        end
      end
      ST_LOW: begin
        if (q.tmr == 12'h000 && q.pend && !q.master_select) begin
          // master left at a byte boundary: stop instead of waiting forever
          n.st = ST_STOP;
          n.sub = `PH_LOW;
          n.act = 1'b0;
          n.pend = 1'b0;
        // held while a byte is pending
        end else if (q.tmr == 12'h000 && !q.pend) begin
          n.st = ST_HIGH;
          n.hs = 1'b0;
          n.tmr = half(q.br);
        end
      end
      ST_HIGH: begin
        if (!q.hs) begin
          // wait for the line to really rise
          if (q.scl_s) begin
            n.hs = 1'b1;
            n.tmr = half(q.br);
          end
        end else if (!q.scl_s) begin
          // another master ended our high period early
          n.st = ST_LOW;
          n.tmr = half(q.br);
        end else if (q.tmr == 12'h000) begin
          n.st = ST_LOW;
          n.tmr = half(q.br);
          if (q.cnt == `CNT_ACK) begin
            if (q.tx && q.sda_s) begin
              n.no_ack_flag = 1'b1;
              n.master_select = 1'b0;
            end
            if (!n.master_select) begin
              n.st = ST_STOP;
              n.sub = `PH_LOW;
              n.act = 1'b0;
            end else if (q.repeat_start_enable) begin
              n.st = ST_RSTRT;
              n.sub = `PH_LOW;
              n.act = 1'b0;
            end
          end
        end
      end
      ST_STOP, ST_RSTRT: begin
        if (q.tmr == 12'h000) begin
          n.tmr = half(q.br);
          if (q.sub == `PH_EDGE) begin
            n.st = (q.st == ST_STOP) ? ST_IDLE : ST_LOW;
            // cleared once the repeated start is done
            if (q.st == ST_RSTRT) n.repeat_start_enable = 1'b0;
          end else begin
            n.sub = q.sub + 2'h1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // condition detection, set wins over the clear strobe
    if (sdet) begin
      n.bus_busy_flag = 1'b1;
      // next start ends the PEC marking
      n.pec_next_byte = 1'b0;
      n.act = 1'b1;
      n.adr = 1'b1;
      n.cnt = `CNT_PRE;
      n.pend = 1'b0;
      n.ackd = 1'b0;
      n.crc_result_reg = 8'h00;
      n.tx = (q.st == ST_START || q.st == ST_RSTRT);
      if (n.tx) n.sh = {q.own_address[`F_SADDR], q.master_direction};
    end
    if (pdet) begin
      n.bus_busy_flag = 1'b0;
      n.act = 1'b0;
    end
    if (q.act && sr && q.cnt < `CNT_ACK) begin
      // released a one but the line reads zero
      if (q.tx && q.sh[7] && !q.sda_s && mstst) begin
        // drop to slave receive, no stop generated
        n.arb_lost_flag = 1'b1;
        n.master_select = 1'b0;
        n.tx = 1'b0;
        n.st = ST_IDLE;
        n.sh = {q.sh[6:0], q.sda_s};
      end else if (!q.tx) begin
        n.sh = {q.sh[6:0], q.sda_s};
      end
    end
    if (q.act && sr && q.cnt == `CNT_ACK && q.tx) n.rx_nak = q.sda_s;
    if (q.act && sf) begin
      // transmit rotates so a lost byte still ends up as received data
      if (q.tx && q.cnt <= `CNT_LAST) n.sh = {q.sh[6:0], q.sh[7]};
      if (q.cnt == `CNT_PRE) begin
        n.cnt = 4'h0;
      end else if (q.cnt < `CNT_LAST) begin
        n.cnt = q.cnt + 4'h1;
      end else if (q.cnt == `CNT_LAST) begin
        n.cnt = `CNT_ACK;
        if (q.adr && !q.tx) begin
          // own, general call and fixed second address
          // bit zero carries the caller's direction
          if (q.sh[`F_SADDR] == q.own_address[`F_SADDR] ||
              (q.own_address[`B_EXT] &&
               (q.sh[`F_SADDR] == `GEN_CALL || q.sh[`F_SADDR] == `EXT_ADDR))) begin
            n.addr_match = 1'b1;
            n.slave_rw = q.sh[0];
            n.ackd = 1'b1;
          end else begin
            n.act = 1'b0;
          end
        end else if (q.tx) begin
          n.crc_result_reg = crc8(q.crc_result_reg, {q.sh[6:0], q.sh[7]});
          n.crc_full = 1'b1;
        end else begin
          n.addr_match = 1'b0;
          n.pend = 1'b1;
        end
      end else begin
        n.cnt = 4'h0;
        n.ackd = 1'b0;
        if (q.adr) begin
          n.adr = 1'b0;
          n.tx = mstst ? ~q.master_direction : q.slave_rw;
        end
        if (q.tx && q.rx_nak) begin
          // end of data, release the line
          if (!mstst) n.act = 1'b0;
        end else if (n.tx) begin
          n.pend = 1'b1;
        end
      end
    end
    // pending byte: stretch the clock until the buffer allows progress
    if (q.pend) begin
      if (q.tx) begin
        if (!q.tx_empty) begin
          n.sh = q.tx_byte;
          n.tx_empty = 1'b1;
          n.tx_done_flag = 1'b1;
          n.pend = 1'b0;
        end
      end else if (!q.rx_full) begin
        n.rx_byte = q.sh;
        n.rx_full = 1'b1;
        n.rx_done_flag = 1'b1;
        n.pend = 1'b0;
        n.crc_result_reg = c;
        n.crc_full = 1'b1;
        if (q.pec_next_byte) n.crc_err = (c != 8'h00);
        // master keeps the suppress choice on the PEC byte
        // slave withholds on a failed PEC byte
        n.ackd = !q.ack_suppress && !(q.pec_next_byte && c != 8'h00 && !mstst);
      end
    end
    if (!n.master_select) n.repeat_start_enable = 1'b0;

    // disabled unit holds every flag except crc_err at its reset value
    if (!q.module_enable_bit) begin
      n.st = ST_IDLE;
      n.act = 1'b0;
      n.pend = 1'b0;
      n.arb_lost_flag = 1'b0;
      n.no_ack_flag = 1'b0;
      n.bus_busy_flag = 1'b0;
      n.master_select = 1'b0;
      n.repeat_start_enable = 1'b0;
      n.rx_done_flag = 1'b0;
      n.tx_done_flag = 1'b0;
      n.addr_match = 1'b0;
      n.slave_rw = 1'b0;
      n.rx_nak = 1'b1;
      n.crc_full = 1'b0;
      n.tx_empty = 1'b1;
      n.rx_full = 1'b0;
    end

    n.scl_lo = (n.st == ST_LOW) || (n.act && n.pend) ||
               ((n.st == ST_STOP || n.st == ST_RSTRT) && n.sub == `PH_LOW);
    n.sda_lo = (n.st == ST_START) || (n.st == ST_STOP && n.sub != `PH_EDGE) ||
               (n.st == ST_RSTRT && n.sub == `PH_EDGE) ||
               (n.st == ST_LOW && n.cnt == `CNT_PRE) ||
               (n.act && n.tx && n.cnt <= `CNT_LAST && !n.sh[7]) ||
               (n.act && n.cnt == `CNT_ACK && n.ackd);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= rst_state();
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign awready_out = !q.awv && !q.bv;
  assign wready_out = !q.wv && !q.bv;
  assign bvalid_out = q.bv;
  assign bresp_out = q.berr ? `RESP_ERR : `RESP_OK;
  assign arready_out = !q.rv;
  assign rvalid_out = q.rv;
  assign rdata_out = {24'h000000, q.rd};
  assign rresp_out = q.rerr ? `RESP_ERR : `RESP_OK;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = q.scl_lo;
  assign sda_oe_out = q.sda_lo;
  // four flags gated by the interrupt enable
  assign irq_out = q.interrupt_enable_bit &
                   (q.tx_done_flag | q.rx_done_flag | q.arb_lost_flag | q.no_ack_flag);
endmodule : multi_master_serial_unit
`default_nettype wire

/* File: testbench.sv */
// testbench of the serial unit: registers, master write, no-ack, disable
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_in, rst_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, m_act;
  logic        scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, m_scl_oe, m_sda_oe;
  logic [11:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, rd;
  logic [3:0]  wstrb_in, m_count;
  logic [1:0]  bresp_out, rresp_out, rs;
  logic [7:0]  m_byte;
  int          err_total, checked;
  // open-drain lines with pull-ups
  wire scl_in = !(scl_oe_out || m_scl_oe);
  wire sda_in = !(sda_oe_out || m_sda_oe);
  multi_master_serial_unit uut (.clk_in, .rst_n_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .bready_in,
    .araddr_in, .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
    .scl_in, .scl_out, .scl_oe_out, .sda_in, .sda_out, .sda_oe_out, .irq_out);
  mm_slave_model #(.ADDR(7'h2A)) partner (.clk_in, .scl_in, .sda_in, .stretch_in(8'h28),
    .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe), .byte_out(m_byte), .count_out(m_count),
    .act_out(m_act));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic hang;
    check(32'h0, 32'h1);
    end_of_test();
  endtask : hang
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    awaddr_in <= a;
    wdata_in <= {24'h0, d};
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'b0;
      if (wvalid_in && wready_out) wvalid_in <= 1'b0;
      if (bvalid_out) begin
        rs = bresp_out;
        bready_in <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk_in);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'b0;
      if (rvalid_out) begin
        rd = rdata_out;
        rs = rresp_out;
        rready_in <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_rd
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    axi_rd(a);
    check(rd, e);
  endtask : rd_chk
  // a flag poll is bounded; running out ends the run
  task automatic poll(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v);
    for (int n = 0; n < 600; n++) begin
      axi_rd(a);
      if ((rd[7:0] & m) === v) return;
    end
    hang();
  endtask : poll
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction : crc8
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(12'h120, 32'hA0);
    rd_chk(12'h124, 32'h00);
    rd_chk(12'h128, 32'h00);
    rd_chk(12'h12C, 32'h0A);
    rd_chk(12'h13C, 32'h04);
    axi_rd(12'h100);
    check(rs, 32'h2);
    axi_wr(12'h140, 8'h55);
    check(rs, 32'h2);
  endtask : t_reset
  task automatic t_master;
    axi_wr(12'h13C, 8'h00);
    axi_wr(12'h124, 8'hC0);
    axi_wr(12'h120, 8'h54);
    axi_wr(12'h130, 8'h5A);
    check(irq_out, 32'h0);
    axi_wr(12'h128, 8'h10);
    poll(12'h12C, 8'h40, 8'h40);
    check(irq_out, 32'h1);
    for (int n = 0; n < 3000 && m_count !== 4'h1; n++) @(posedge clk_in);
    if (m_count !== 4'h1) hang();
    check(m_byte, 32'h5A);
    rd_chk(12'h138, crc8(crc8(8'h00, 8'h54), 8'h5A));
    rd_chk(12'h128, 32'h30);
    axi_wr(12'h12C, 8'h00);
    axi_wr(12'h128, 8'h00);
    poll(12'h128, 8'h20, 8'h00);
    check(m_act, 32'h0);
    check(irq_out, 32'h0);
  endtask : t_master
  task automatic t_nak_disable;
    axi_wr(12'h120, 8'h66);
    axi_wr(12'h128, 8'h10);
    poll(12'h128, 8'h40, 8'h40);
    check(rd & 32'h50, 32'h40);
    check(irq_out, 32'h1);
    axi_wr(12'h124, 8'h80);
    check(irq_out, 32'h0);
    poll(12'h128, 8'h20, 8'h00);
    axi_wr(12'h124, 8'hA0);
    rd_chk(12'h124, 32'h80);
    axi_wr(12'h124, 8'h00);
    rd_chk(12'h128, 32'h00);
    rd_chk(12'h12C, 32'h0A);
  endtask : t_nak_disable
  initial begin
    {rst_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 6'h0;
    {awaddr_in, araddr_in, wdata_in} = 56'h0;
    wstrb_in = 4'h1;
    err_total = 0;
    checked = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_master();
    t_nak_disable();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
